// ---- logic/cmd_key.sv ----
// Purpose: Debounce of one key with press and long-press pulses.
// Assumes: Raw key is active low and asynchronous to clk_sys.
// Notes:   Long press fires once per hold; a short press fires on release.
`timescale 1ns/1ps
module cmd_key #(
	parameter int DEB_CYC  = cmd_pkg::DEBOUNCE_CYC,
	parameter int LONG_CYC = cmd_pkg::LONG_CYC
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Key pin
	input  wire logic key_n,
	// Events
	output logic      press,
	output logic      long_press
);
	import cmd_pkg::*;

	logic             s1_q, s2_q;
	logic             st_q, st_d;
	logic             lg_q, lg_d;
	logic [CNT_W-1:0] db_q, db_d;
	logic [CNT_W-1:0] hold_q, hold_d;
	logic             pr_q, pr_d, lp_q, lp_d;

	// Two-stage synchroniser, first stage read only by the second
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
		end else begin
			s1_q <= key_n;
			s2_q <= s1_q;
		end
	end

	// Stable level must persist for the debounce time before it counts
	always_comb begin
		st_d   = st_q;
		db_d   = db_q;
		hold_d = hold_q;
		lg_d   = lg_q;
		pr_d   = 1'b0;
		lp_d   = 1'b0;
		if (!s2_q == st_q) begin
			db_d = '0;
		end else if (db_q >= CNT_W'(DEB_CYC - 1)) begin
			db_d = '0;
			st_d = !s2_q;
			if (st_q && !lg_q) begin
				pr_d = 1'b1;
			end
			if (!st_q) begin
				lg_d = 1'b0;
			end
		end else begin
			db_d = db_q + 1'b1;
		end
		// Hold timer for long press
		if (st_q && !lg_q) begin
			if (hold_q >= CNT_W'(LONG_CYC - 1)) begin
				lp_d = 1'b1;
				lg_d = 1'b1;
			end else begin
				hold_d = hold_q + 1'b1;
			end
		end else if (!st_q) begin
			hold_d = '0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q   <= 1'b0;
			lg_q   <= 1'b0;
			db_q   <= '0;
			hold_q <= '0;
			pr_q   <= 1'b0;
			lp_q   <= 1'b0;
		end else begin
			st_q   <= st_d;
			lg_q   <= lg_d;
			db_q   <= db_d;
			hold_q <= hold_d;
			pr_q   <= pr_d;
			lp_q   <= lp_d;
		end
	end

	assign press      = pr_q;
	assign long_press = lp_q;
endmodule

// ---- logic/cmd_pkg.sv ----
// Purpose: Shared constants and types of the clock menu and display control.
// Assumes: One clock at 250 MHz; keys active low from push buttons.
// Notes:   All cycle counts derive from times in their own units.
package cmd_pkg;
	localparam int CLK_MHZ        = 250;
	localparam int DEBOUNCE_US    = 10000;
	localparam int DEBOUNCE_CYC   = DEBOUNCE_US * CLK_MHZ;
	localparam int LONG_MS        = 1000;
	localparam int LONG_CYC       = LONG_MS * 1000 * CLK_MHZ;
	localparam int ALT_MS         = 4000;
	localparam int ALT_CYC        = ALT_MS * 1000 * CLK_MHZ;
	localparam int DECODE_S       = 60;
	localparam int CNT_W          = 32;
	localparam int NKEYS          = 4;
	localparam int KEY_MNEXT      = 0;
	localparam int KEY_MPREV      = 1;
	localparam int KEY_PLUS       = 2;
	localparam int KEY_MINUS      = 3;
	localparam int DIGITS         = 6;
	localparam int MAIN_N         = 10;
	localparam int ALARM_N        = 8;
	localparam logic [7:0] BRIGHT_FULL = 8'hff;
	localparam logic [7:0] BRIGHT_OFF  = 8'h00;
	localparam logic [2:0] DP_ORIENT   = 3'h0;
	localparam logic [5:0] DECODE_INIT = 6'h3c;

	typedef enum logic [3:0] {
		CMD_M_NORMAL, CMD_M_VIEW, CMD_M_TEMP, CMD_M_ALARM, CMD_M_BRIGHT,
		CMD_M_RECV, CMD_M_CLOCK, CMD_M_INFO, CMD_M_CHIP, CMD_M_FW
	} cmd_main_e;

	typedef enum logic [2:0] {
		CMD_A_DAYS, CMD_A_ENABLE, CMD_A_HOUR, CMD_A_MIN, CMD_A_SNOOZE,
		CMD_A_WAIT, CMD_A_MAXT, CMD_A_EXIT
	} cmd_alarm_e;

	typedef enum logic [1:0] {
		CMD_V_BLANK, CMD_V_CLOCK, CMD_V_YMD, CMD_V_ALT
	} cmd_view_e;

	typedef enum logic [1:0] {
		CMD_S_NOSIG, CMD_S_SEARCH, CMD_S_DECODE, CMD_S_LOCKED
	} cmd_sync_e;

	typedef enum logic [2:0] {
		CMD_SH_TIME, CMD_SH_DATE, CMD_SH_TEMP, CMD_SH_DASH,
		CMD_SH_NOSIG, CMD_SH_SEARCH, CMD_SH_DECODE, CMD_SH_MENU
	} cmd_show_e;
endpackage

// ---- logic/cmd_top.sv ----
// Purpose: Menu navigation and display selection of a radio clock.
// Assumes: Decoder status, second tick and temperature come from logic on
//          clk_sys; key pins are asynchronous.
// Notes:   Values inside settings are owned elsewhere; this block emits
//          increment and decrement strobes for the selected item.
`timescale 1ns/1ps
module cmd_top #(
	parameter int DEB_CYC  = cmd_pkg::DEBOUNCE_CYC,
	parameter int LONG_CYC = cmd_pkg::LONG_CYC,
	parameter int ALT_CYC  = cmd_pkg::ALT_CYC
) (
	// Clock and reset
	input  wire logic               clk_sys,
	input  wire logic               resetn,
	// Key pins, active low
	input  wire logic [3:0]         key_n,
	// Decoder status, brightness settings and temperature flag
	input  wire logic               sig_valid,
	input  wire logic               marker_found,
	input  wire logic               sec_tick,
	input  wire logic [7:0]         recv_bright,
	input  wire logic [7:0]         norm_bright,
	input  wire logic               temp_ok,
	// Menu state
	output cmd_pkg::cmd_main_e      main_item,
	output logic                    in_menu,
	output logic                    in_alarm_sub,
	output cmd_pkg::cmd_alarm_e     alarm_item,
	output logic                    inc_pulse,
	output logic                    dec_pulse,
	output logic                    cal_temp_pulse,
	output logic                    cal_offs_pulse,
	// Settings
	output cmd_pkg::cmd_view_e      view_mode,
	output logic                    temp_on,
	output logic                    alarm_toggled,
	output logic                    flashlight,
	// Display
	output cmd_pkg::cmd_show_e      show,
	output logic [5:0]              decode_count,
	output logic [7:0]              bright,
	output logic [5:0]              dp_mask
);
	import cmd_pkg::*;

	logic [NKEYS-1:0] kp, kl;

	// One debouncer per key
	for (genvar i = 0; i < NKEYS; i++) begin : g_key
		cmd_key #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_key (
			.clk_sys    (clk_sys),
			.resetn     (resetn),
			.key_n      (key_n[i]),
			.press      (kp[i]),
			.long_press (kl[i])
		);
	end

	// Wrapping step over an enumerated ring of given length
	function automatic logic [3:0] step(input logic [3:0] cur,
		input logic fwd, input logic [3:0] n);
		if (fwd) begin
			step = (cur == n - 4'h1) ? 4'h0 : cur + 4'h1;
		end else begin
			step = (cur == 4'h0) ? n - 4'h1 : cur - 4'h1;
		end
	endfunction

	cmd_main_e  main_q, main_d;
	cmd_alarm_e asub_q, asub_d;
	cmd_view_e  view_q, view_d;
	cmd_sync_e  sync_q, sync_d;
	logic       menu_q, menu_d, sub_q, sub_d;
	logic       temp_q, temp_d, alm_q, alm_d, fl_q, fl_d;
	logic       inc_q, inc_d, dec_q, dec_d, ct_q, ct_d, co_q, co_d;
	logic [5:0] dcnt_q, dcnt_d;
	logic [CNT_W-1:0] alt_q, alt_d;
	logic       phase_q, phase_d;
	logic [1:0] ph3_q, ph3_d;

	// Menu navigation and key actions
	always_comb begin
		main_d = main_q;
		asub_d = asub_q;
		view_d = view_q;
		menu_d = menu_q;
		sub_d  = sub_q;
		temp_d = temp_q;
		alm_d  = alm_q;
		fl_d   = fl_q;
		inc_d  = 1'b0;
		dec_d  = 1'b0;
		ct_d   = 1'b0;
		co_d   = 1'b0;
		if (kp[KEY_MNEXT] || kp[KEY_MPREV]) begin
			fl_d = 1'b0;
			if (!menu_q) begin
				menu_d = 1'b1;
				main_d = CMD_M_VIEW;
			end else if (sub_q) begin
				asub_d = cmd_alarm_e'(3'(step({1'b0, asub_q}, kp[KEY_MNEXT],
					4'(ALARM_N))));
			end else begin
				main_d = cmd_main_e'(step(main_q, kp[KEY_MNEXT],
					4'(MAIN_N)));
				menu_d = (main_d != CMD_M_NORMAL);
			end
		end else if (kl[KEY_PLUS] && main_q == CMD_M_TEMP) begin
			ct_d = 1'b1;
		end else if (kl[KEY_MINUS] && main_q == CMD_M_TEMP) begin
			co_d = 1'b1;
		end else if (kp[KEY_PLUS]) begin
			if (sub_q && asub_q == CMD_A_EXIT) begin
				sub_d = 1'b0;
			end else if (sub_q) begin
				inc_d = 1'b1;
			end else begin
				unique case (main_q)
					CMD_M_NORMAL: alm_d = !alm_q;
					CMD_M_VIEW:   view_d = cmd_view_e'(view_q + 2'h1);
					CMD_M_TEMP:   temp_d = 1'b1;
					CMD_M_ALARM: begin
						sub_d  = 1'b1;
						asub_d = CMD_A_DAYS;
					end
					default:      inc_d = 1'b1;
				endcase
			end
		end else if (kp[KEY_MINUS]) begin
			if (sub_q) begin
				dec_d = 1'b1;
			end else begin
				unique case (main_q)
					CMD_M_NORMAL: fl_d = !fl_q;
					CMD_M_VIEW:   view_d = cmd_view_e'(view_q - 2'h1);
					CMD_M_TEMP:   temp_d = 1'b0;
					default:      dec_d = 1'b1;
				endcase
			end
		end
	end

	// Sync status with decode countdown over one minute
	always_comb begin
		sync_d = sync_q;
		dcnt_d = dcnt_q;
		if (!sig_valid) begin
			sync_d = CMD_S_NOSIG;
		end else begin
			unique case (sync_q)
				CMD_S_NOSIG: sync_d = CMD_S_SEARCH;
				CMD_S_SEARCH: if (marker_found) begin
					sync_d = CMD_S_DECODE;
					dcnt_d = DECODE_INIT;
				end
				CMD_S_DECODE: if (sec_tick) begin
					if (dcnt_q == 6'h01) begin
						sync_d = CMD_S_LOCKED;
					end
					dcnt_d = dcnt_q - 6'h01;
				end
				CMD_S_LOCKED: sync_d = CMD_S_LOCKED;
			endcase
		end
	end

	// Alternation timer between time, date and temperature
	always_comb begin
		alt_d   = alt_q + 1'b1;
		phase_d = phase_q;
		ph3_d   = ph3_q;
		if (alt_q >= CNT_W'(ALT_CYC - 1)) begin
			alt_d   = '0;
			phase_d = !phase_q;
			ph3_d   = (ph3_q == 2'h2) ? 2'h0 : ph3_q + 2'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			main_q  <= CMD_M_NORMAL;
			asub_q  <= CMD_A_DAYS;
			view_q  <= CMD_V_ALT;
			sync_q  <= CMD_S_NOSIG;
			menu_q  <= 1'b0;
			sub_q   <= 1'b0;
			temp_q  <= 1'b0;
			alm_q   <= 1'b0;
			fl_q    <= 1'b0;
			inc_q   <= 1'b0;
			dec_q   <= 1'b0;
			ct_q    <= 1'b0;
			co_q    <= 1'b0;
			dcnt_q  <= '0;
			alt_q   <= '0;
			phase_q <= 1'b0;
			ph3_q   <= 2'h0;
		end else begin
			main_q  <= main_d;
			asub_q  <= asub_d;
			view_q  <= view_d;
			sync_q  <= sync_d;
			menu_q  <= menu_d;
			sub_q   <= sub_d;
			temp_q  <= temp_d;
			alm_q   <= alm_d;
			fl_q    <= fl_d;
			inc_q   <= inc_d;
			dec_q   <= dec_d;
			ct_q    <= ct_d;
			co_q    <= co_d;
			dcnt_q  <= dcnt_d;
			alt_q   <= alt_d;
			phase_q <= phase_d;
			ph3_q   <= ph3_d;
		end
	end

	// Display content; menu outranks sync status so setup stays usable
	cmd_show_e  show_c;
	logic [7:0] bright_c;
	logic [5:0] dp_c;
	logic       tshow;
	always_comb begin
		tshow    = temp_q && temp_ok;
		bright_c = fl_q ? BRIGHT_FULL : norm_bright;
		dp_c     = '0;
		show_c   = CMD_SH_TIME;
		if (menu_q) begin
			show_c = CMD_SH_MENU;
		end else if (sync_q != CMD_S_LOCKED) begin
			unique case (sync_q)
				CMD_S_NOSIG:  show_c = CMD_SH_NOSIG;
				CMD_S_SEARCH: show_c = CMD_SH_SEARCH;
				default:      show_c = CMD_SH_DECODE;
			endcase
			if (recv_bright == BRIGHT_OFF) begin
				bright_c = BRIGHT_OFF;
				dp_c[DP_ORIENT] = 1'b1;
			end else begin
				bright_c = recv_bright;
			end
		end else begin
			unique case (view_q)
				CMD_V_BLANK: show_c = tshow ? CMD_SH_TEMP : CMD_SH_DASH;
				CMD_V_CLOCK: show_c = (tshow && phase_q) ? CMD_SH_TEMP
					: CMD_SH_TIME;
				CMD_V_YMD:   show_c = (tshow && phase_q) ? CMD_SH_TEMP
					: CMD_SH_DATE;
				CMD_V_ALT: begin
					if (ph3_q == 2'h2) begin
						show_c = tshow ? CMD_SH_TEMP : CMD_SH_TIME;
					end else begin
						show_c = ph3_q[0] ? CMD_SH_DATE : CMD_SH_TIME;
					end
				end
			endcase
		end
	end

	cmd_show_e  show_q;
	logic [7:0] bright_q;
	logic [5:0] dp_q;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			show_q   <= CMD_SH_NOSIG;
			bright_q <= '0;
			dp_q     <= '0;
		end else begin
			show_q   <= show_c;
			bright_q <= bright_c;
			dp_q     <= dp_c;
		end
	end

	assign main_item      = main_q;
	assign in_menu        = menu_q;
	assign in_alarm_sub   = sub_q;
	assign alarm_item     = asub_q;
	assign inc_pulse      = inc_q;
	assign dec_pulse      = dec_q;
	assign cal_temp_pulse = ct_q;
	assign cal_offs_pulse = co_q;
	assign view_mode      = view_q;
	assign temp_on        = temp_q;
	assign alarm_toggled  = alm_q;
	assign flashlight     = fl_q;
	assign show           = show_q;
	assign decode_count   = dcnt_q;
	assign bright         = bright_q;
	assign dp_mask        = dp_q;
endmodule

// ---- sim/cmd_btn_model.sv ----
// Purpose: Push-button bank holding one key down for a set time.
// Assumes: Commands arrive off the rising edge.
// Notes:   Released keys sit at the pull-up level, high.
`timescale 1ns/1ps
module cmd_btn_model (
	// Clock
	input  wire logic        clk_sys,
	// Command
	input  wire logic        go,
	input  wire logic [1:0]  sel,
	input  wire logic [7:0]  hold,
	// Pins
	output logic [3:0]       key_n
);
	logic [7:0] cnt_q;
	initial begin
		key_n = 4'hf;
		cnt_q = 8'h00;
	end
	// Held time must exceed the debounce span to be seen at all
	always @(posedge clk_sys) begin
		if (go && cnt_q == 8'h00) begin
			key_n <= ~(4'h1 << sel);
			cnt_q <= hold;
		end else if (cnt_q > 8'h01) begin
			cnt_q <= cnt_q - 8'h01;
		end else if (cnt_q == 8'h01) begin
			key_n <= 4'hf;
			cnt_q <= 8'h00;
		end
	end
endmodule

// ---- sim/cmd_monitor.sv ----
// Purpose: Port-level timing checks of the menu and display control.
// Assumes: One clock domain; bench holds settings steady between steps.
// Notes:   Bound to every cmd_top instance.
`timescale 1ns/1ps
module cmd_monitor
	import cmd_pkg::*;
(
	// Clock, reset and inputs
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        marker_found,
	input wire logic        sec_tick,
	input wire logic [7:0]  recv_bright,
	// Outputs
	input wire cmd_main_e   main_item,
	input wire logic        in_menu,
	input wire logic        in_alarm_sub,
	input wire cmd_alarm_e  alarm_item,
	input wire logic        inc_pulse,
	input wire logic        dec_pulse,
	input wire logic        cal_temp_pulse,
	input wire logic        cal_offs_pulse,
	input wire cmd_view_e   view_mode,
	input wire logic        flashlight,
	input wire cmd_show_e   show,
	input wire logic [5:0]  decode_count,
	input wire logic [7:0]  bright,
	input wire logic [5:0]  dp_mask
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Count load may lag the marker by the show register
	sequence s_full;
		##[1:3] decode_count == DECODE_INIT;
	endsequence
	// Status views, checked only once the setting has settled
	chk_status_bright: assert property (show inside {CMD_SH_NOSIG,
		CMD_SH_SEARCH, CMD_SH_DECODE} && recv_bright != 8'h00 &&
		$past(recv_bright, 2) == recv_bright |-> bright == recv_bright)
		else $error("status brightness wrong");
	chk_blank_sync: assert property ($past(resetn) && show inside {
		CMD_SH_NOSIG, CMD_SH_SEARCH, CMD_SH_DECODE} && recv_bright == 8'h00 &&
		$past(recv_bright, 2) == 8'h00 |-> bright == 8'h00 &&
		dp_mask == 6'h01) else $error("blanked sync view wrong");
	chk_count_step: assert property (sec_tick && show == CMD_SH_DECODE &&
		decode_count > 6'h01 |=> decode_count == $past(decode_count) - 6'h01)
		else $error("decode count step wrong");
	chk_marker_load: assert property (show == CMD_SH_SEARCH &&
		marker_found |-> s_full) else $error("decode count not loaded");
	chk_menu_show: assert property (in_menu |=> show == CMD_SH_MENU)
		else $error("menu not shown");
	chk_pulse_once: assert property (inc_pulse || dec_pulse |=>
		!inc_pulse && !dec_pulse) else $error("strobe too long");
	chk_sub_step: assert property (in_alarm_sub && $past(in_alarm_sub) &&
		alarm_item != $past(alarm_item) |-> 3'(alarm_item -
		$past(alarm_item)) inside {3'h1, 3'h7}) else $error("sub step wrong");
	chk_cal_item: assert property (cal_temp_pulse || cal_offs_pulse |->
		in_menu && main_item == CMD_M_TEMP) else $error("calibration stray");
	chk_flash_full: assert property (flashlight && $past(flashlight) &&
		show inside {CMD_SH_TIME, CMD_SH_DATE} |-> bright == BRIGHT_FULL)
		else $error("flashlight not full");
	chk_blank_view: assert property (view_mode == CMD_V_BLANK &&
		$past(view_mode) == CMD_V_BLANK && !in_menu && !$past(in_menu) |->
		!(show inside {CMD_SH_TIME, CMD_SH_DATE})) else $error("blank shows time");
endmodule
bind cmd_top cmd_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn),
	.marker_found(marker_found), .sec_tick(sec_tick),
	.recv_bright(recv_bright), .main_item(main_item), .in_menu(in_menu),
	.in_alarm_sub(in_alarm_sub), .alarm_item(alarm_item),
	.inc_pulse(inc_pulse), .dec_pulse(dec_pulse),
	.cal_temp_pulse(cal_temp_pulse), .cal_offs_pulse(cal_offs_pulse),
	.view_mode(view_mode), .flashlight(flashlight), .show(show),
	.decode_count(decode_count), .bright(bright), .dp_mask(dp_mask));

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the menu and display control.
// Assumes: Short debounce, long-press and alternation counts.
// Notes:   Notes queue feeds a checker process at each settle point.
`timescale 1ns/1ps
module tb;
	import cmd_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic sig_valid = 1'b0;
	logic marker_found = 1'b0;
	logic sec_tick = 1'b0;
	logic [7:0] recv_bright = 8'h00;
	logic [7:0] norm_bright = 8'h40;
	logic temp_ok = 1'b1;
	logic go = 1'b0;
	logic [1:0] ksel = 2'h0;
	logic [7:0] khold = 8'h0a;
	logic [3:0] key_n;
	cmd_main_e main_item;
	cmd_alarm_e alarm_item;
	cmd_view_e view_mode;
	cmd_show_e show;
	logic in_menu, in_alarm_sub, inc_pulse, dec_pulse, cal_temp_pulse;
	logic cal_offs_pulse, temp_on, alarm_toggled, flashlight;
	logic [5:0] decode_count, dp_mask;
	logic [7:0] bright;
	logic [3:0] flg = 4'h0;
	logic [11:0] notes[$];
	int errors = 0;
	int check_count = 0;
	event chk_ev;
	always #2 clk_sys = ~clk_sys;
	cmd_btn_model u_btn (.clk_sys(clk_sys), .go(go), .sel(ksel),
		.hold(khold), .key_n(key_n));
	cmd_top #(.DEB_CYC(4), .LONG_CYC(40), .ALT_CYC(20)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .key_n(key_n),
		.sig_valid(sig_valid), .marker_found(marker_found),
		.sec_tick(sec_tick), .recv_bright(recv_bright),
		.norm_bright(norm_bright), .temp_ok(temp_ok), .main_item(main_item),
		.in_menu(in_menu), .in_alarm_sub(in_alarm_sub),
		.alarm_item(alarm_item), .inc_pulse(inc_pulse),
		.dec_pulse(dec_pulse), .cal_temp_pulse(cal_temp_pulse),
		.cal_offs_pulse(cal_offs_pulse), .view_mode(view_mode),
		.temp_on(temp_on), .alarm_toggled(alarm_toggled),
		.flashlight(flashlight), .show(show), .decode_count(decode_count),
		.bright(bright), .dp_mask(dp_mask));
	// Strobes last one cycle, so latch them until the next press
	always @(posedge clk_sys)
		flg <= flg | {cal_temp_pulse, cal_offs_pulse, inc_pulse, dec_pulse};
	function automatic logic [7:0] act(input logic [3:0] s);
		case (s)
			4'h0: act = {4'h0, main_item};
			4'h1: act = {7'h0, in_menu};
			4'h2: act = {7'h0, in_alarm_sub};
			4'h3: act = {5'h0, alarm_item};
			4'h4: act = {6'h0, view_mode};
			4'h5: act = {7'h0, temp_on};
			4'h6: act = {7'h0, alarm_toggled};
			4'h7: act = {7'h0, flashlight};
			4'h8: act = {5'h0, show};
			4'h9: act = bright;
			4'ha: act = {2'h0, dp_mask};
			4'hb: act = {2'h0, decode_count};
			4'hc: act = {flg, 4'h0};
			default: act = {7'h0, (show inside {CMD_SH_TIME, CMD_SH_DATE})};
		endcase
	endfunction
	task automatic cmp(input logic [11:0] n);
		logic [7:0] a;
		a = act(n[11:8]);
		check_count++;
		if (a !== n[7:0]) begin
			errors++;
			$display("[ERR] %0t item %0h got %0h want %0h", $time, n[11:8], a,
				n[7:0]);
		end
	endtask
	// Checker process: oldest note first
	always @(chk_ev)
		while (notes.size() > 0)
			cmp(notes.pop_front());
	task automatic note(input logic [3:0] s, input logic [7:0] v);
		notes.push_back({s, v});
	endtask
	task automatic settle();
		repeat (3) @(negedge clk_sys);
		-> chk_ev;
		@(negedge clk_sys);
	endtask
	task automatic press(input int k, input int h);
		flg = 4'h0;
		ksel = 2'(k);
		khold = 8'(h);
		go = 1'b1;
		@(negedge clk_sys);
		go = 1'b0;
		repeat (h + 16) @(negedge clk_sys);
	endtask
	task automatic nav(input int k, input int m, input logic o);
		press(k, 10);
		note(4'h0, 8'(m));
		note(4'h1, {7'h0, o});
		settle();
	endtask
	task automatic done(input string t);
		$display("test %s finished", t);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog well beyond the expected two thousand or so cycles
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
	// Main sequence
	initial begin
		void'($urandom(32'haa84));
		repeat (10) @(negedge clk_sys);
		resetn = 1'b1;
		note(4'h8, {5'h0, CMD_SH_NOSIG});
		note(4'h9, 8'h00);
		note(4'ha, 8'h01);
		note(4'h4, {6'h0, CMD_V_ALT});
		settle();
		recv_bright = 8'($urandom_range(255, 1));
		norm_bright = 8'($urandom);
		note(4'h9, recv_bright);
		settle();
		sig_valid = 1'b1;
		note(4'h8, {5'h0, CMD_SH_SEARCH});
		settle();
		marker_found = 1'b1;
		@(negedge clk_sys);
		marker_found = 1'b0;
		note(4'hb, 8'h3c);
		settle();
		for (int i = 0; i < 60; i++) begin
			if (i == 59)
				note(4'h8, {5'h0, CMD_SH_DECODE});
			settle();
			sec_tick = 1'b1;
			@(negedge clk_sys);
			sec_tick = 1'b0;
		end
		note(4'hd, 8'h01);
		settle();
		done("sync");
		press(2, 10);
		note(4'h6, 8'h01);
		press(3, 10);
		note(4'h7, 8'h01);
		note(4'h9, BRIGHT_FULL);
		settle();
		for (int i = 1; i <= 10; i++)
			nav(0, i % 10, i < 10);
		note(4'h7, 8'h00);
		nav(1, 1, 1'b1);
		nav(1, 0, 1'b0);
		done("normal and ring");
		nav(0, 1, 1'b1);
		for (int j = 2; j >= 0; j--) begin
			press(3, 10);
			note(4'h4, 8'(j));
			settle();
		end
		nav(0, 2, 1'b1);
		press(2, 10);
		note(4'h5, 8'h01);
		press(2, 60);
		note(4'hc, 8'h80);
		note(4'h5, 8'h01);
		settle();
		press(3, 60);
		note(4'hc, 8'h40);
		settle();
		press(3, 10);
		note(4'h5, 8'h00);
		settle();
		done("view and temperature");
		nav(0, 3, 1'b1);
		press(2, 10);
		note(4'h2, 8'h01);
		note(4'h3, {5'h0, CMD_A_DAYS});
		settle();
		for (int i = 1; i <= 8; i++) begin
			press(0, 10);
			note(4'h3, 8'(i % 8));
			settle();
		end
		press(1, 10);
		note(4'h3, {5'h0, CMD_A_EXIT});
		press(2, 10);
		note(4'h2, 8'h00);
		settle();
		nav(0, 4, 1'b1);
		press(2, 10);
		note(4'hc, 8'h20);
		settle();
		press(3, 10);
		note(4'hc, 8'h10);
		settle();
		for (int m = 5; m <= 10; m++)
			nav(0, m % 10, m < 10);
		note(4'h8, {5'h0, CMD_SH_DASH});
		settle();
		done("alarm and values");
		// Blank view with temperature enabled, then temperature lost
		nav(0, 1, 1'b1);
		nav(0, 2, 1'b1);
		press(2, 10);
		note(4'h5, 8'h01);
		nav(1, 1, 1'b1);
		nav(1, 0, 1'b0);
		note(4'h8, {5'h0, CMD_SH_TEMP});
		settle();
		temp_ok = 1'b0;
		note(4'h8, {5'h0, CMD_SH_DASH});
		settle();
		done("blank with temperature");
		summarize();
	end
endmodule
